// File: dmd_pkg.sv
// Constants and types for the data memory address decoder.
// Assumes one system clock; every importer uses dmd_pkg::*.
//
// Summary of operation
// - Upper half: indirect to RAM, direct to registers.
// - Lower half same RAM either mode.
// - First 32 bytes: four banks of eight.
// - Next 16 bytes byte and bit addressable.
// - Register window decoded with 256-page selector.
// - On-chip 4 kB block aliases over 64 k.
// - Three external-data mappings selectable.
// - Split: below 4 k on-chip, above external.
// - External port multiplexed or separate lines.
// - Program memory erased in 512-byte sectors.
// - 64 k variant: top 1024 bytes reserved.
// - Scratchpad sector at 0x10000 to 0x1007F.
// - 32 k variant: 0x8000 to 0xFFFF reserved.
package dmd_pkg;

  // ****************************************************
  // Internal data space layout.
  // ****************************************************
  localparam logic [7:0] UPPER_HALF_BASE = 8'h80;
  localparam logic [7:0] BANK_AREA_END   = 8'h1f;
  localparam logic [7:0] BIT_AREA_BASE   = 8'h20;
  localparam logic [7:0] BIT_AREA_END    = 8'h2f;
  localparam logic [7:0] PAGE_RESET      = 8'h00;

  // ****************************************************
  // External data space layout.
  // ****************************************************
  localparam int         XRAM_AW     = 12;
  localparam logic [15:0] SPLIT_LIMIT = 16'h1000;

  // ****************************************************
  // Program memory layout.
  // ****************************************************
  localparam logic [16:0] PM_TOP_SMALL  = 17'h07fff;
  localparam logic [16:0] PM_TOP_LARGE  = 17'h0fbff;
  localparam logic [16:0] SCRATCH_BASE  = 17'h10000;
  localparam logic [16:0] SCRATCH_TOP   = 17'h1007f;
  localparam int          SECTOR_SHIFT  = 9;
  localparam logic [7:0]  FILL_BYTE     = 8'hff;

  // External-data mapping choices; 2'b11 is illegal.
  typedef enum logic [1:0] {
    XMAP_ONCHIP  = 2'b00,
    XMAP_SPLIT   = 2'b01,
    XMAP_OFFCHIP = 2'b10
  } dmd_xmap_e;

  localparam logic [1:0] XMAP_RESET = 2'b00;

endpackage

// File: dmd_sync3.sv
// Three-stage synchroniser for slow configuration pins.
// Assumes the pins change rarely; a change is taken once the
// second and third stages agree.
`timescale 1ns/1ps
module dmd_sync3 #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous level in, filtered level out.
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] level_r
);

  logic [W-1:0] s1_r;  // First stage, read only by the second.
  logic [W-1:0] s2_r;  // Second stage.
  logic [W-1:0] s3_r;  // Third stage.

  // Shift chain; reset loads constants only.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a new level only when two stages agree, which
  // rejects a value caught mid-transition.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_r <= RST;
    end else if (s2_r == s3_r) begin
      level_r <= s3_r;
    end
  end

endmodule // dmd_sync3

// File: dmd_decoder.sv
// Address decoder for the core's data and program spaces.
// Assumes the core holds each request for one cycle and reads
// the decoded selects one cycle later.
`timescale 1ns/1ps
module dmd_decoder
  import dmd_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Configuration pins, asynchronous.
  input  wire logic [1:0]  cfgMapPin,
  input  wire logic        cfgSmallPin,
  input  wire logic        cfgMuxPin,
  // Internal data requests from the core.
  input  wire logic        iReq,
  input  wire logic [7:0]  iAddr,
  input  wire logic        iIndirect,
  input  wire logic        iRegReq,
  input  wire logic [1:0]  iBank,
  input  wire logic [2:0]  iRegNum,
  input  wire logic        iBitReq,
  input  wire logic [7:0]  iBitAddr,
  input  wire logic        pageWr,
  input  wire logic [7:0]  pageData,
  // Internal data routing.
  output logic             ramSel_r,
  output logic [7:0]       ramAddr_r,
  output logic             sfrSel_r,
  output logic [6:0]       sfrAddr_r,
  output logic [7:0]       sfrPage_r,
  output logic             bitOp_r,
  output logic [2:0]       bitPos_r,
  // External data requests and routing.
  input  wire logic        xReq,
  input  wire logic [15:0] xAddr,
  output logic             xramSel_r,
  output logic [XRAM_AW-1:0] xramAddr_r,
  output logic             extSel_r,
  output logic [15:0]      extAddr_r,
  output logic             extMux_r,
  // Program memory requests and routing.
  input  wire logic        pReq,
  input  wire logic        pWe,
  input  wire logic        pErase,
  input  wire logic [16:0] pAddr,
  output logic             flashSel_r,
  output logic [15:0]      flashAddr_r,
  output logic             flashWe_r,
  output logic             flashErase_r,
  output logic [6:0]       eraseSector_r,
  output logic             scratchSel_r,
  output logic [6:0]       scratchAddr_r,
  output logic             scratchWe_r,
  output logic             scratchErase_r,
  output logic             pmFillOnes_r,
  output logic [7:0]       pmFill_r
);

  // ****************************************************
  // Configuration capture.
  // ****************************************************
  logic [1:0] mapSync;    // Filtered mapping pins.
  logic       smallSync;  // Filtered size variant pin.
  logic       muxSync;    // Filtered port arrangement pin.
  logic [1:0] xmap_r;     // Mapping in force.
  logic       small_r;    // High on the 32 k variant.

  dmd_sync3 #(.W(2), .RST(XMAP_RESET)) uMapSync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pinIn   (cfgMapPin),
    .level_r (mapSync)
  );

  dmd_sync3 #(.W(2), .RST(2'b00)) uCfgSync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pinIn   ({cfgSmallPin, cfgMuxPin}),
    .level_r ({smallSync, muxSync})
  );

  // Latched settings steer every access after the one in
  // flight, so a change never splits a single access.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xmap_r   <= XMAP_RESET;
      small_r  <= 1'b0;
      extMux_r <= 1'b0;
    end else begin
      xmap_r   <= mapSync;
      small_r  <= smallSync;
      extMux_r <= muxSync;
    end
  end

  // ****************************************************
  // Register page selector.
  // ****************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sfrPage_r <= PAGE_RESET;
    end else if (pageWr) begin
      sfrPage_r <= pageData;
    end
  end

  // ****************************************************
  // Internal data decode.
  // ****************************************************
  // Bit requests win over register requests, which win over
  // plain byte requests; the core issues one at a time.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ramSel_r  <= 1'b0;
      ramAddr_r <= 8'h00;
      sfrSel_r  <= 1'b0;
      sfrAddr_r <= 7'h00;
      bitOp_r   <= 1'b0;
      bitPos_r  <= 3'h0;
    end else begin
      ramSel_r <= 1'b0;
      sfrSel_r <= 1'b0;
      bitOp_r  <= 1'b0;
      if (iBitReq) begin
        bitOp_r  <= 1'b1;
        bitPos_r <= iBitAddr[2:0];
        if (!iBitAddr[7]) begin
          // Bits 0x00..0x7f sit in the 16-byte area.
          ramSel_r  <= 1'b1;
          ramAddr_r <= BIT_AREA_BASE | {4'h0, iBitAddr[6:3]};
        end else begin
          // Upper bit addresses hit registers at multiples of eight.
          sfrSel_r  <= 1'b1;
          sfrAddr_r <= {iBitAddr[6:3], 3'h0};
        end
      end else if (iRegReq) begin
        // Working register: bank picks the group of eight.
        ramSel_r  <= 1'b1;
        ramAddr_r <= {3'h0, iBank, iRegNum};
      end else if (iReq) begin
        if (!iAddr[7] || iIndirect) begin
          ramSel_r  <= 1'b1;
          ramAddr_r <= iAddr;
        end else begin
          sfrSel_r  <= 1'b1;
          sfrAddr_r <= iAddr[6:0];
        end
      end
    end
  end

  // ****************************************************
  // External data decode.
  // ****************************************************
  logic xOnchip; // Current access goes to the 4 kB block.

  always_comb begin
    unique case (xmap_r)
      XMAP_ONCHIP:  xOnchip = 1'b1;
      XMAP_SPLIT:   xOnchip = (xAddr < SPLIT_LIMIT);
      XMAP_OFFCHIP: xOnchip = 1'b0;
      default:      xOnchip = 1'b1;
    endcase
  end

  // On-chip block ignores the upper address bits, so it
  // repeats every 4 kB across the whole range.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xramSel_r  <= 1'b0;
      xramAddr_r <= '0;
      extSel_r   <= 1'b0;
      extAddr_r  <= 16'h0000;
    end else begin
      xramSel_r <= xReq && xOnchip;
      extSel_r  <= xReq && !xOnchip;
      if (xReq) begin
        xramAddr_r <= xAddr[XRAM_AW-1:0];
        extAddr_r  <= xAddr;
      end
    end
  end

  // ****************************************************
  // Program memory decode.
  // ****************************************************
  logic pScratch;  // Access in the scratchpad sector.
  logic pUser;     // Access in user program space.
  logic [16:0] pTop; // Last user address of this variant.

  assign pTop     = small_r ? PM_TOP_SMALL : PM_TOP_LARGE;
  assign pScratch = (pAddr >= SCRATCH_BASE)
                    && (pAddr <= SCRATCH_TOP);
  assign pUser    = (pAddr <= pTop);

  // Reserved and unmapped addresses raise neither select, so
  // nothing stored can change; the read answer is all ones.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flashSel_r     <= 1'b0;
      flashAddr_r    <= 16'h0000;
      flashWe_r      <= 1'b0;
      flashErase_r   <= 1'b0;
      eraseSector_r  <= 7'h00;
      scratchSel_r   <= 1'b0;
      scratchAddr_r  <= 7'h00;
      scratchWe_r    <= 1'b0;
      scratchErase_r <= 1'b0;
      pmFillOnes_r   <= 1'b0;
      pmFill_r       <= 8'h00;
    end else begin
      flashSel_r     <= pReq && pUser;
      flashWe_r      <= pReq && pUser && pWe && !pErase;
      flashErase_r   <= pReq && pUser && pErase;
      scratchSel_r   <= pReq && pScratch;
      scratchWe_r    <= pReq && pScratch && pWe && !pErase;
      scratchErase_r <= pReq && pScratch && pErase;
      pmFillOnes_r   <= pReq && !pUser && !pScratch;
      pmFill_r       <= (pReq && !pUser && !pScratch)
                        ? FILL_BYTE : 8'h00;
      if (pReq) begin
        flashAddr_r   <= pAddr[15:0];
        eraseSector_r <= pAddr[15:SECTOR_SHIFT];
        scratchAddr_r <= pAddr[6:0];
      end
    end
  end

  // ****************************************************
  // Checks.
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sDirectUpper;
    iReq && !iRegReq && !iBitReq && iAddr[7] && !iIndirect;
  endsequence

  sequence sPageSet;
    pageWr ##1 !pageWr [*2];
  endsequence

  a_upper_direct: assert property (sDirectUpper |=>
    sfrSel_r && !ramSel_r && sfrAddr_r == $past(iAddr[6:0]))
    else $error("direct upper access not sent to registers");

  a_upper_indirect: assert property (
    iReq && !iRegReq && !iBitReq && iAddr[7] && iIndirect
    |=> ramSel_r && ramAddr_r == $past(iAddr))
    else $error("indirect upper access not sent to RAM");

  a_lower_same: assert property (
    iReq && !iRegReq && !iBitReq && !iAddr[7]
    |=> ramSel_r && !sfrSel_r && ramAddr_r == $past(iAddr))
    else $error("lower half access misrouted");

  a_reg_bank: assert property (iRegReq && !iBitReq
    |=> ramSel_r && ramAddr_r <= BANK_AREA_END
        && ramAddr_r[2:0] == $past(iRegNum)
        && ramAddr_r[4:3] == $past(iBank))
    else $error("working register address wrong");

  a_bit_area: assert property (iBitReq && !iBitAddr[7]
    |=> ramSel_r && bitOp_r && ramAddr_r >= BIT_AREA_BASE
        && ramAddr_r <= BIT_AREA_END
        && bitPos_r == $past(iBitAddr[2:0]))
    else $error("bit address outside bit area");

  a_page_hold: assert property (
    sPageSet |-> sfrPage_r == $past(pageData, 2))
    else $error("register page not held");

  a_xram_alias: assert property (xReq && xOnchip
    |=> xramSel_r && !extSel_r
        && xramAddr_r == $past(xAddr[XRAM_AW-1:0]))
    else $error("on-chip block alias wrong");

  a_split_map: assert property (
    xReq && xmap_r == XMAP_SPLIT
    |=> xramSel_r == ($past(xAddr) < SPLIT_LIMIT)
        && extSel_r == ($past(xAddr) >= SPLIT_LIMIT))
    else $error("split mapping boundary wrong");

  a_offchip_map: assert property (
    xReq && xmap_r == XMAP_OFFCHIP |=> extSel_r && !xramSel_r)
    else $error("off-chip mapping reached on-chip block");

  a_cfg_follow: assert property (
    mapSync != xmap_r |=> xmap_r == $past(mapSync))
    else $error("mapping setting not taken");

  a_small_res: assert property (
    pReq && small_r && pAddr >= 17'h08000
    && pAddr < SCRATCH_BASE
    |=> !flashSel_r && !flashWe_r && pmFillOnes_r)
    else $error("reserved area of small variant written");

  a_large_res: assert property (
    pReq && !small_r && pAddr > PM_TOP_LARGE
    && pAddr < SCRATCH_BASE
    |=> !flashSel_r && pmFill_r == FILL_BYTE)
    else $error("reserved top kilobyte not blocked");

  a_scratch_sel: assert property (pReq && pScratch
    |=> scratchSel_r && !flashSel_r
        && scratchAddr_r == $past(pAddr[6:0]))
    else $error("scratchpad access misrouted");

  a_erase_sector: assert property (
    pReq && pUser && pErase
    |=> flashErase_r && !flashWe_r
        && eraseSector_r == $past(pAddr[15:9]))
    else $error("erase sector number wrong");

endmodule // dmd_decoder

// File: dmd_core_model.sv
// Behavioural model of the core that issues requests to the decoder.
// Assumes the decoder takes a request at a rising edge and answers one
// cycle later; each task returns at the falling edge where it is settled.
`timescale 1ns/1ps
module dmd_core_model (
  // Clock.
  input  wire logic clk,
  // Internal data requests.
  output logic        iReq,
  output logic [7:0]  iAddr,
  output logic        iIndirect,
  output logic        iRegReq,
  output logic [1:0]  iBank,
  output logic [2:0]  iRegNum,
  output logic        iBitReq,
  output logic [7:0]  iBitAddr,
  output logic        pageWr,
  output logic [7:0]  pageData,
  // External data requests.
  output logic        xReq,
  output logic [15:0] xAddr,
  // Program memory requests.
  output logic        pReq,
  output logic        pWe,
  output logic        pErase,
  output logic [16:0] pAddr
);
  // Start idle so nothing is seen as a request during reset.
  initial begin
    {iReq, iIndirect, iRegReq, iBitReq, pageWr, xReq, pReq} = '0;
    {pWe, pErase, iAddr, iBank, iRegNum, iBitAddr, pageData} = '0;
    {xAddr, pAddr} = '0;
  end

  // Kind 0 byte, 1 working register, 2 bit, 3 page load.
  // Released byte, bit and page address lines flip so a stale address never looks valid; iBank and iRegNum keep their value.
  task automatic iAcc(input int k, input logic [7:0] a, input logic ind);
    @(negedge clk);
    iIndirect = ind;
    {iBank, iRegNum} = a[4:0];
    {iAddr, iBitAddr, pageData} = {3{a}};
    {iReq, iRegReq, iBitReq, pageWr} = {k == 0, k == 1, k == 2, k == 3};
    @(negedge clk);
    {iReq, iRegReq, iBitReq, pageWr} = 4'h0;
    {iAddr, iBitAddr, pageData} = {3{~a}};
  endtask

  // One external-data access.
  task automatic xAcc(input logic [15:0] a);
    @(negedge clk);
    {xReq, xAddr} = {1'b1, a};
    @(negedge clk);
    {xReq, xAddr} = {1'b0, ~a};
  endtask

  // One program-space access; erase outranks write.
  task automatic pAcc(input logic [16:0] a, input logic we, input logic er);
    @(negedge clk);
    {pReq, pWe, pErase, pAddr} = {1'b1, we, er, a};
    @(negedge clk);
    {pReq, pWe, pErase, pAddr} = {3'h0, ~a};
  endtask
endmodule // dmd_core_model

// File: test_data_memory_address_decoder.sv
// Self-checking bench for the address decoder.
// Assumes the core model drives all requests; pins are set here.
`timescale 1ns/1ps
module test_data_memory_address_decoder
  import dmd_pkg::*;
;
  // ************************************
  // Signals.
  // ************************************
  logic clk = 1'b0, rst_n = 1'b0, cfgSmallPin = 1'b0, cfgMuxPin = 1'b1;
  logic [1:0] cfgMapPin = 2'b10;
  logic iReq, iIndirect, iRegReq, iBitReq, pageWr, xReq, pReq, pWe, pErase;
  logic [7:0] iAddr, iBitAddr, pageData, ramAddr_r, sfrPage_r, pmFill_r;
  logic [1:0] iBank;
  logic [2:0] iRegNum, bitPos_r;
  logic [15:0] xAddr, extAddr_r, flashAddr_r;
  logic [16:0] pAddr;
  logic ramSel_r, sfrSel_r, bitOp_r, xramSel_r, extSel_r, extMux_r;
  logic flashSel_r, flashWe_r, flashErase_r, scratchSel_r, scratchWe_r;
  logic scratchErase_r, pmFillOnes_r;
  logic [6:0] sfrAddr_r, eraseSector_r, scratchAddr_r;
  logic [XRAM_AW-1:0] xramAddr_r;
  int fails = 0, n_tests = 0;

  // Twenty nanosecond clock.
  always #10 clk = ~clk;

  dmd_decoder i_dmd_decoder (.clk, .rst_n, .cfgMapPin, .cfgSmallPin,
    .cfgMuxPin, .iReq, .iAddr, .iIndirect, .iRegReq, .iBank, .iRegNum,
    .iBitReq, .iBitAddr, .pageWr, .pageData, .ramSel_r, .ramAddr_r,
    .sfrSel_r, .sfrAddr_r, .sfrPage_r, .bitOp_r, .bitPos_r, .xReq, .xAddr,
    .xramSel_r, .xramAddr_r, .extSel_r, .extAddr_r, .extMux_r, .pReq, .pWe,
    .pErase, .pAddr, .flashSel_r, .flashAddr_r, .flashWe_r, .flashErase_r,
    .eraseSector_r, .scratchSel_r, .scratchAddr_r, .scratchWe_r,
    .scratchErase_r, .pmFillOnes_r, .pmFill_r);

  dmd_core_model i_dmd_core_model (.clk, .iReq, .iAddr, .iIndirect,
    .iRegReq, .iBank, .iRegNum, .iBitReq, .iBitAddr, .pageWr, .pageData,
    .xReq, .xAddr, .pReq, .pWe, .pErase, .pAddr);

  // ************************************
  // Checking and closing.
  // ************************************
  task automatic ck(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d.", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ************************************
  // Scenarios.
  // ************************************
  // Pins ask for off-chip, but the filter has not caught up yet.
  task automatic tReset;
    ck(sfrPage_r, 8'h00);
    i_dmd_core_model.xAcc(16'h5678);
    ck(xramSel_r, 1'b1);
    ck(xramAddr_r, 12'h678);
    ck(extMux_r, 1'b0);
  endtask

  task automatic tInternal;
    i_dmd_core_model.iAcc(0, 8'h90, 1'b0);
    ck({sfrSel_r, ramSel_r, sfrAddr_r}, {2'b10, 7'h10});
    i_dmd_core_model.iAcc(0, 8'h90, 1'b1);
    ck({sfrSel_r, ramSel_r, ramAddr_r}, {2'b01, 8'h90});
    for (int m = 0; m < 2; m++) begin
      i_dmd_core_model.iAcc(0, 8'h35, m[0]);
      ck({sfrSel_r, ramSel_r, ramAddr_r}, {2'b01, 8'h35});
    end
    for (int b = 0; b < 4; b++) begin
      i_dmd_core_model.iAcc(1, {3'h0, b[1:0], 3'h7}, 1'b0);
      ck({ramSel_r, ramAddr_r}, {1'b1, 3'h0, b[1:0], 3'h7});
    end
    i_dmd_core_model.iAcc(2, 8'h2b, 1'b0);
    ck({ramSel_r, bitOp_r, bitPos_r, ramAddr_r}, {5'h1b, 8'h25});
    i_dmd_core_model.iAcc(3, 8'ha5, 1'b0);
    ck(sfrPage_r, 8'ha5);
    i_dmd_core_model.iAcc(2, 8'h93, 1'b0);
    ck({sfrSel_r, bitOp_r, bitPos_r, sfrAddr_r}, {5'h1b, 7'h10});
  endtask

  // Pins need five edges to land; six are allowed before the access.
  task automatic xCase(input logic [1:0] m, input logic [15:0] a,
                       input logic on);
    cfgMapPin = m;
    repeat (6) @(negedge clk);
    i_dmd_core_model.xAcc(a);
    ck({xramSel_r, extSel_r}, {on, ~on});
    if (on) ck(xramAddr_r, a[11:0]);
    else ck(extAddr_r, a);
    ck(extMux_r, 1'b1);
  endtask

  // Kind 0 flash, 1 scratchpad, 2 reserved.
  task automatic pCase(input logic sm, input logic [16:0] a,
                       input logic we, input logic er, input int k);
    cfgSmallPin = sm;
    repeat (6) @(negedge clk);
    i_dmd_core_model.pAcc(a, we, er);
    ck({flashSel_r, scratchSel_r, pmFillOnes_r}, 3'h4 >> k);
    ck(pmFill_r, (k == 2) ? 8'hff : 8'h00);
    ck({flashWe_r, flashErase_r}, {k == 0 && we && !er, k == 0 && er});
    ck(scratchErase_r, k == 1 && er);
    ck(scratchWe_r, k == 1 && we && !er);
    if (k == 0) ck(flashAddr_r, a[15:0]);
    if (k == 0 && er) ck(eraseSector_r, a[15:9]);
    if (k == 1) ck(scratchAddr_r, a[6:0]);
  endtask

  // ************************************
  // Main sequence and watchdog.
  // ************************************
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    tReset();
    tInternal();
    xCase(2'b00, 16'hf123, 1'b1);
    xCase(2'b10, 16'h0123, 1'b0);
    xCase(2'b01, 16'h0fff, 1'b1);
    xCase(2'b01, 16'h1000, 1'b0);
    xCase(2'b11, 16'h9abc, 1'b1);
    pCase(1'b0, 17'h00400, 1'b0, 1'b1, 0);
    pCase(1'b0, 17'h0fbff, 1'b1, 1'b0, 0);
    pCase(1'b0, 17'h0fc00, 1'b1, 1'b0, 2);
    pCase(1'b0, 17'h1007f, 1'b1, 1'b0, 1);
    pCase(1'b0, 17'h10080, 1'b1, 1'b0, 2);
    pCase(1'b1, 17'h07fff, 1'b1, 1'b0, 0);
    pCase(1'b1, 17'h08000, 1'b1, 1'b0, 2);
    pCase(1'b1, 17'h10000, 1'b0, 1'b1, 1);
    close_out();
  end

  // The run needs about 140 cycles; twenty times that means a hang.
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule // test_data_memory_address_decoder
